// file: design/frm_fault_response_manager.sv
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module frm_fault_response_manager
(
   input wire logic clock,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Fault sources, high while present
   input wire logic [5:0] fault_sources,
   // Telemetry for peak tracking
   input wire logic [15:0] vout_sample,
   input wire logic [15:0] iout_sample,
   input wire logic [11:0] die_temperature,
   // Nonvolatile access request from the serial engine
   input wire logic nvm_request,
   input wire logic nvm_is_fault_log,
   output logic nvm_grant,
   // PWM demand from the control loop
   input wire logic pwm_top,
   input wire logic pwm_bottom,
   output logic top_gate_drive,
   output logic bottom_gate_drive,
   // Open-drain lines: input, output, output enable (low = driving)
   input wire logic fault_line_in,
   output logic fault_line_out,
   output logic fault_line_oe_n,
   input wire logic sync_line_in,
   output logic sync_line_out,
   output logic sync_line_oe_n,
   input wire logic timebase_line_in,
   output logic timebase_line_out,
   output logic timebase_line_oe_n,
   input wire logic channel_run_pin_in,
   output logic channel_run_pin_out,
   output logic channel_run_pin_oe_n,
   output logic power_good_output_out,
   output logic power_good_output_oe_n,
   input wire logic power_good,
   output logic sync_seen,
   output logic timebase_low_seen
);
   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   logic fault_sync;
   logic sync_sync;
   logic timebase_sync;
   logic run_sync;

   frm_sync u_fault_sync (.clock(clock), .reset(reset), .async_in(fault_line_in),
      .sync_out(fault_sync));
   frm_sync u_sync_sync (.clock(clock), .reset(reset), .async_in(sync_line_in),
      .sync_out(sync_sync));
   frm_sync u_tb_sync (.clock(clock), .reset(reset), .async_in(timebase_line_in),
      .sync_out(timebase_sync));
   frm_sync u_run_sync (.clock(clock), .reset(reset), .async_in(channel_run_pin_in),
      .sync_out(run_sync));

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [6:0] fault_enable;
   logic [13:0] response;
   logic [15:0] retry_interval_setting;
   logic [3:0] control;
   logic [11:0] temp_high;
   logic [11:0] temp_low;
   logic [15:0] peak_vout;
   logic [15:0] peak_iout;
   logic [11:0] peak_temp;
   logic [6:0] log_faults;
   logic [15:0] log_count;
   logic [6:0] next_fault_enable;
   logic [13:0] next_response;
   logic [15:0] next_retry_interval_setting;
   logic [3:0] next_control;
   logic [11:0] next_temp_high;
   logic [11:0] next_temp_low;
   logic [15:0] next_peak_vout;
   logic [15:0] next_peak_iout;
   logic [11:0] next_peak_temp;
   logic [6:0] next_log_faults;
   logic [15:0] next_log_count;
   logic [31:0] next_readdata;
   logic read_pending;
   logic next_read_pending;
   logic peak_clear;

   // Response code of one fault class
   function automatic frm_pkg::frm_resp_t resp_of(input logic [13:0] r, input int idx);
      resp_of = frm_pkg::frm_resp_t'(r[idx*2 +: 2]);
   endfunction

   // ----------------------------------------------------------------
   // Fault evaluation
   // ----------------------------------------------------------------
   logic [6:0] fault_vector;
   logic [6:0] latch_hits;
   logic [6:0] retry_hits;
   logic shutdown_event;
   logic retry_event;
   logic latch_event;
   frm_pkg::frm_state_t state;
   frm_pkg::frm_state_t next_state;
   logic [15:0] retry_units;
   logic [15:0] next_retry_units;
   logic [7:0] unit_count;
   logic [7:0] next_unit_count;
   logic nvm_blocked;
   logic next_nvm_blocked;

   // External low on the shared line counts as a seventh fault class
   assign fault_vector = {~fault_sync, fault_sources};

   // Classify each active fault by its configured response
   genvar g;
   generate
      for (g = 0; g < frm_pkg::NUM_FAULTS; g++)
      begin : g_class
         assign latch_hits[g] = fault_vector[g] &&
            resp_of(response, g) == frm_pkg::RESP_LATCH;
         assign retry_hits[g] = fault_vector[g] &&
            resp_of(response, g) == frm_pkg::RESP_RETRY;
      end
   endgenerate

   assign latch_event = |latch_hits;
   assign retry_event = |retry_hits;
   assign shutdown_event = (state == frm_pkg::ST_RUN) && (latch_event || retry_event);

   // Shutdown state machine
   always_comb
   begin
      next_state = state;
      next_retry_units = retry_units;
      next_unit_count = unit_count;
      unique case (state)
         frm_pkg::ST_RUN:
         begin
            if (latch_event)
               next_state = frm_pkg::ST_LATCHED;
            else if (retry_event)
            begin
               next_state = frm_pkg::ST_RETRY_WAIT;
               next_retry_units = retry_interval_setting;
               next_unit_count = 8'h00;
            end
         end
         frm_pkg::ST_LATCHED:
         begin
            if (control[frm_pkg::CTRL_CLEAR_LATCH])
               next_state = frm_pkg::ST_RUN;
         end
         frm_pkg::ST_RETRY_WAIT:
         begin
            // Retry indefinitely: restart once the interval has elapsed
            if (unit_count == 8'(frm_pkg::RETRY_UNIT_CYCLES - 1))
            begin
               next_unit_count = 8'h00;
               if (retry_units == 16'h0000)
                  next_state = frm_pkg::ST_RUN;
               else
                  next_retry_units = retry_units - 16'h0001;
            end
            else
               next_unit_count = unit_count + 8'h01;
         end
      endcase
   end

   // Die-temperature hysteresis for nonvolatile access
   always_comb
   begin
      next_nvm_blocked = nvm_blocked;
      if (die_temperature > temp_high)
         next_nvm_blocked = 1'b1;
      else if (die_temperature < temp_low)
         next_nvm_blocked = 1'b0;
   end

   // ----------------------------------------------------------------
   // Fault log and peaks
   // ----------------------------------------------------------------
   always_comb
   begin
      next_peak_vout = peak_vout;
      next_peak_iout = peak_iout;
      next_peak_temp = peak_temp;
      next_log_faults = log_faults;
      next_log_count = log_count;
      if (peak_clear)
      begin
         next_peak_vout = vout_sample; // Sample in the clear cycle wins
         next_peak_iout = iout_sample;
         next_peak_temp = die_temperature;
      end
      else
      begin
         // Running peaks, always tracked
         if (vout_sample > peak_vout)
            next_peak_vout = vout_sample;
         if (iout_sample > peak_iout)
            next_peak_iout = iout_sample;
         if (die_temperature > peak_temp)
            next_peak_temp = die_temperature;
      end
      // Capture on shutdown when logging is enabled
      if (shutdown_event && control[frm_pkg::CTRL_LOG_ENABLE])
      begin
         next_log_faults = fault_vector;
         next_log_count = log_count + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Line timing: sync pulse and timebase
   // ----------------------------------------------------------------
   logic [11:0] tb_count;
   logic [11:0] next_tb_count;
   logic [8:0] sync_count;
   logic [8:0] next_sync_count;

   always_comb
   begin
      if (tb_count == 12'(frm_pkg::TIMEBASE_PERIOD_CYCLES - 1))
         next_tb_count = 12'h000;
      else
         next_tb_count = tb_count + 12'h001;
      if (sync_count == 9'(frm_pkg::SYNC_PERIOD_CYCLES - 1))
         next_sync_count = 9'h000;
      else
         next_sync_count = sync_count + 9'h001;
   end

   // ----------------------------------------------------------------
   // Avalon-MM slave: writes in one cycle, reads wait one cycle
   // ----------------------------------------------------------------
   assign waitrequest = read && !read_pending;
   assign peak_clear = write && address == frm_pkg::ADDR_PEAK_VOUT;

   always_comb
   begin
      next_fault_enable = fault_enable;
      next_response = response;
      next_retry_interval_setting = retry_interval_setting;
      next_control = control;
      next_temp_high = temp_high;
      next_temp_low = temp_low;
      next_read_pending = read && !read_pending;
      next_readdata = readdata;
      // Clear-latch bit is a one-shot
      next_control[frm_pkg::CTRL_CLEAR_LATCH] = 1'b0;
      if (write)
      begin
         unique case (address)
            frm_pkg::ADDR_FAULT_ENABLE: next_fault_enable = writedata[6:0];
            frm_pkg::ADDR_RESPONSE: next_response = writedata[13:0];
            frm_pkg::ADDR_RETRY_INTERVAL: next_retry_interval_setting = writedata[15:0];
            frm_pkg::ADDR_CONTROL: next_control = writedata[3:0];
            frm_pkg::ADDR_TEMP_LIMITS:
            begin
               next_temp_high = writedata[27:16];
               next_temp_low = writedata[11:0];
            end
            default: ;
         endcase
      end
      if (read && !read_pending)
      begin
         next_readdata = 32'h0000_0000;
         unique case (address)
            frm_pkg::ADDR_FAULT_ENABLE: next_readdata[6:0] = fault_enable;
            frm_pkg::ADDR_RESPONSE: next_readdata[13:0] = response;
            frm_pkg::ADDR_RETRY_INTERVAL: next_readdata[15:0] = retry_interval_setting;
            frm_pkg::ADDR_CONTROL: next_readdata[3:0] = control;
            frm_pkg::ADDR_STATUS:
            begin
               next_readdata[6:0] = fault_vector;
               next_readdata[frm_pkg::STAT_NVM_BLOCKED] = nvm_blocked;
               next_readdata[frm_pkg::STAT_LATCHED] = state == frm_pkg::ST_LATCHED;
               next_readdata[frm_pkg::STAT_RETRY_WAIT] = state == frm_pkg::ST_RETRY_WAIT;
               next_readdata[frm_pkg::STAT_RUNNING] = state == frm_pkg::ST_RUN;
               next_readdata[frm_pkg::STAT_EXT_FAULT] = ~fault_sync;
            end
            frm_pkg::ADDR_PEAK_VOUT: next_readdata[15:0] = peak_vout;
            frm_pkg::ADDR_PEAK_IOUT: next_readdata[15:0] = peak_iout;
            frm_pkg::ADDR_PEAK_TEMP: next_readdata[11:0] = peak_temp;
            frm_pkg::ADDR_LOG_FAULTS: next_readdata[6:0] = log_faults;
            frm_pkg::ADDR_LOG_COUNT: next_readdata[15:0] = log_count;
            frm_pkg::ADDR_TEMP_LIMITS: next_readdata = {4'h0, temp_high, 4'h0, temp_low};
            default: next_readdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         fault_enable <= frm_pkg::RESET_FAULT_ENABLE;
         response <= frm_pkg::RESET_RESPONSE;
         retry_interval_setting <= frm_pkg::RESET_RETRY_INTERVAL;
         control <= frm_pkg::RESET_CONTROL;
         temp_high <= frm_pkg::RESET_TEMP_HIGH;
         temp_low <= frm_pkg::RESET_TEMP_LOW;
         peak_vout <= 16'h0000;
         peak_iout <= 16'h0000;
         peak_temp <= 12'h000;
         log_faults <= 7'h00;
         log_count <= 16'h0000;
         readdata <= 32'h0000_0000;
         read_pending <= 1'b0;
         state <= frm_pkg::ST_RUN;
         retry_units <= 16'h0000;
         unit_count <= 8'h00;
         nvm_blocked <= 1'b0;
         tb_count <= 12'h000;
         sync_count <= 9'h000;
      end
      else
      begin
         fault_enable <= next_fault_enable;
         response <= next_response;
         retry_interval_setting <= next_retry_interval_setting;
         control <= next_control;
         temp_high <= next_temp_high;
         temp_low <= next_temp_low;
         peak_vout <= next_peak_vout;
         peak_iout <= next_peak_iout;
         peak_temp <= next_peak_temp;
         log_faults <= next_log_faults;
         log_count <= next_log_count;
         readdata <= next_readdata;
         read_pending <= next_read_pending;
         state <= next_state;
         retry_units <= next_retry_units;
         unit_count <= next_unit_count;
         nvm_blocked <= next_nvm_blocked;
         tb_count <= next_tb_count;
         sync_count <= next_sync_count;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic running;
   logic next_top;
   logic next_bottom;
   logic next_fault_low;
   logic next_sync_low;
   logic next_tb_low;
   logic next_run_low;
   logic next_pg_low;
   logic next_grant;

   always_comb
   begin
      running = state == frm_pkg::ST_RUN && run_sync;
      next_top = pwm_top && running;
      next_bottom = pwm_bottom && running;
      if (fault_vector[frm_pkg::FAULT_OV])
      begin
         next_top = 1'b0;
         next_bottom = 1'b1;
      end
      next_fault_low = |(fault_enable[5:0] & fault_sources);
      next_sync_low = control[frm_pkg::CTRL_SYNC_ENABLE] &&
         sync_count < 9'(frm_pkg::SYNC_LOW_CYCLES);
      next_tb_low = tb_count < 12'(frm_pkg::TIMEBASE_LOW_CYCLES);
      next_run_low = !control[frm_pkg::CTRL_RUN] || state == frm_pkg::ST_LATCHED;
      next_pg_low = !power_good || !running;
      // Every request waits while hot, fault logging included; nvm_is_fault_log is not used
      next_grant = nvm_request && !nvm_blocked;
   end

   // Open-drain outputs only ever drive zero
   assign fault_line_out = 1'b0;
   assign sync_line_out = 1'b0;
   assign timebase_line_out = 1'b0;
   assign channel_run_pin_out = 1'b0;
   assign power_good_output_out = 1'b0;

   // Registered drives and enables
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         top_gate_drive <= 1'b0;
         bottom_gate_drive <= 1'b0;
         fault_line_oe_n <= 1'b1;
         sync_line_oe_n <= 1'b1;
         timebase_line_oe_n <= 1'b1;
         channel_run_pin_oe_n <= 1'b0;
         power_good_output_oe_n <= 1'b0;
         nvm_grant <= 1'b0;
         sync_seen <= 1'b0;
         timebase_low_seen <= 1'b0;
      end
      else
      begin
         top_gate_drive <= next_top;
         bottom_gate_drive <= next_bottom;
         fault_line_oe_n <= !next_fault_low;
         sync_line_oe_n <= !next_sync_low;
         timebase_line_oe_n <= !next_tb_low;
         channel_run_pin_oe_n <= !next_run_low;
         power_good_output_oe_n <= !next_pg_low;
         nvm_grant <= next_grant;
         sync_seen <= !sync_sync;
         timebase_low_seen <= !timebase_sync;
      end
   end
endmodule // frm_fault_response_manager
`default_nettype wire

// file: design/frm_pkg.sv
package frm_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [5:0] ADDR_FAULT_ENABLE = 6'h00;
   localparam logic [5:0] ADDR_RESPONSE = 6'h04;
   localparam logic [5:0] ADDR_RETRY_INTERVAL = 6'h08;
   localparam logic [5:0] ADDR_CONTROL = 6'h0C;
   localparam logic [5:0] ADDR_STATUS = 6'h10;
   localparam logic [5:0] ADDR_PEAK_VOUT = 6'h14;
   localparam logic [5:0] ADDR_PEAK_IOUT = 6'h18;
   localparam logic [5:0] ADDR_PEAK_TEMP = 6'h1C;
   localparam logic [5:0] ADDR_LOG_FAULTS = 6'h20;
   localparam logic [5:0] ADDR_LOG_COUNT = 6'h24;
   localparam logic [5:0] ADDR_TEMP_LIMITS = 6'h28;

   // ----------------------------------------------------------------
   // Fault classes and field positions
   // ----------------------------------------------------------------
   localparam int NUM_FAULTS = 7;
   localparam int FAULT_OV = 0;
   localparam int FAULT_UV = 1;
   localparam int FAULT_OC = 2;
   localparam int FAULT_OT = 3;
   localparam int FAULT_TIMING = 4;
   localparam int FAULT_PEAK_OC = 5;
   localparam int FAULT_EXTERNAL = 6;
   localparam int CTRL_LOG_ENABLE = 0;
   localparam int CTRL_SYNC_ENABLE = 1;
   localparam int CTRL_RUN = 2;
   localparam int CTRL_CLEAR_LATCH = 3;
   localparam int STAT_NVM_BLOCKED = 8;
   localparam int STAT_LATCHED = 9;
   localparam int STAT_RETRY_WAIT = 10;
   localparam int STAT_RUNNING = 11;
   localparam int STAT_EXT_FAULT = 12;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [6:0] RESET_FAULT_ENABLE = 7'h3F;
   localparam logic [13:0] RESET_RESPONSE = 14'h0AAA;
   localparam logic [15:0] RESET_RETRY_INTERVAL = 16'h0064;
   localparam logic [3:0] RESET_CONTROL = 4'h7;
   localparam logic [11:0] RESET_TEMP_HIGH = 12'h082;
   localparam logic [11:0] RESET_TEMP_LOW = 12'h078;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLOCK_MHZ = 250;
   localparam int SYNC_LOW_NS = 500;
   localparam int SYNC_LOW_CYCLES = SYNC_LOW_NS * CLOCK_MHZ / 1000;
   localparam int TIMEBASE_PERIOD_NS = 10000;
   localparam int TIMEBASE_PERIOD_CYCLES = TIMEBASE_PERIOD_NS * CLOCK_MHZ / 1000;
   localparam int TIMEBASE_LOW_NS = 1000;
   localparam int TIMEBASE_LOW_CYCLES = TIMEBASE_LOW_NS * CLOCK_MHZ / 1000;
   localparam int RETRY_UNIT_NS = 1000;
   localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_NS * CLOCK_MHZ / 1000;
   localparam int SYNC_PERIOD_NS = 2000;
   localparam int SYNC_PERIOD_CYCLES = SYNC_PERIOD_NS * CLOCK_MHZ / 1000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {RESP_IGNORE, RESP_LATCH, RESP_RETRY, RESP_SPARE} frm_resp_t;
   typedef enum logic [1:0] {ST_RUN, ST_LATCHED, ST_RETRY_WAIT} frm_state_t;
endpackage

// file: design/frm_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop level synchroniser for one open-drain line
module frm_sync
(
   input wire logic clock,
   input wire logic reset,
   input wire logic async_in,
   output logic sync_out
);
   logic stage_one;
   logic next_stage_one;
   logic next_sync_out;

   // Idle level of an open-drain line is high
   always_comb
   begin
      next_stage_one = async_in;
      next_sync_out = stage_one;
   end

   // Only the second flop reads the first
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         stage_one <= 1'b1;
         sync_out <= 1'b1;
      end
      else
      begin
         stage_one <= next_stage_one;
         sync_out <= next_sync_out;
      end
   end
endmodule // frm_sync
`default_nettype wire

// file: test/frm_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// Other controllers and pull-ups on the shared open-drain lines
module frm_peer_model
(
   input wire logic fault_oe_n,
   input wire logic sync_oe_n,
   input wire logic timebase_oe_n,
   input wire logic run_oe_n,
   input wire logic pull_fault,
   input wire logic pull_sync,
   output logic fault_w,
   output logic sync_w,
   output logic timebase_w,
   output logic run_w
);
   // Wired-AND with pull-ups; peers only ever pull low
   assign fault_w = fault_oe_n & !pull_fault;
   assign sync_w = sync_oe_n & !pull_sync;
   assign timebase_w = timebase_oe_n;
   assign run_w = run_oe_n;
endmodule // frm_peer_model
`default_nettype wire

// file: test/frm_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the fault response manager
module frm_checker_sva
(
   input wire logic clock,
   input wire logic reset,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   input wire logic [5:0] fault_sources,
   input wire logic [11:0] die_temperature,
   input wire logic nvm_grant,
   input wire logic top_gate_drive,
   input wire logic bottom_gate_drive,
   input wire logic fault_line_out,
   input wire logic fault_line_oe_n,
   input wire logic sync_line_in,
   input wire logic sync_line_out,
   input wire logic sync_line_oe_n,
   input wire logic timebase_line_in,
   input wire logic timebase_line_out,
   input wire logic timebase_line_oe_n,
   input wire logic channel_run_pin_out,
   input wire logic power_good_output_out,
   input wire logic sync_seen,
   input wire logic timebase_low_seen
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic [11:0] sync_cnt;
   logic [11:0] tb_cnt;
   // Length of the current low drive on sync and timebase
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         sync_cnt <= 12'h000;
         tb_cnt <= 12'h000;
      end
      else
      begin
         sync_cnt <= sync_line_oe_n ? 12'h000 : sync_cnt + 12'h001;
         tb_cnt <= timebase_line_oe_n ? 12'h000 : tb_cnt + 12'h001;
      end
   end
   a_ov_forces_gates:
   assert property (fault_sources[0] |=> !top_gate_drive && bottom_gate_drive)
      else $error("gates not forced on overvoltage");
   a_lines_low_only:
   assert property (!(fault_line_out | sync_line_out | timebase_line_out
      | channel_run_pin_out | power_good_output_out)) else $error("pin driven high");
   a_sync_pulse_len:
   assert property ($rose(sync_line_oe_n) |-> sync_cnt == 12'h07D)
      else $error("sync low time wrong");
   a_timebase_low_len:
   assert property ($rose(timebase_line_oe_n) |-> tb_cnt == 12'h0FA)
      else $error("timebase low time wrong");
   a_fault_line_released:
   assert property ((fault_sources == 6'h00) [*4] |-> fault_line_oe_n)
      else $error("fault line held without a source");
   a_hot_blocks_nvm:
   assert property ((die_temperature > 12'h082) [*4] |-> !nvm_grant)
      else $error("nvm granted while hot");
   a_sync_seen_follows:
   assert property (!sync_line_in [*4] |=> sync_seen) else $error("sync low not seen");
   a_timebase_seen_idle:
   assert property (timebase_line_in [*4] |=> !timebase_low_seen)
      else $error("timebase low seen while high");
   a_read_one_wait:
   assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
      else $error("read wait state wrong");
   a_write_no_wait:
   assert property (write |-> !waitrequest) else $error("write stalled");
endmodule // frm_checker_sva
bind frm_fault_response_manager frm_checker_sva u_sva (.*);
`default_nettype wire

// file: test/fault_response_manager_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Bus-driven bench with a read scoreboard
module fault_response_manager_tb_top;
   logic clock, reset, read, write, nvmr, pt, pb, pf, ps, grant, tg, bg, wreq;
   logic foe, soe, toe, roe, fw, sw, tw, rw, pgo;
   logic [5:0] address, fs;
   logic [31:0] writedata, rdata, e, m;
   logic [15:0] vout, iout;
   logic [11:0] temp;
   logic [31:0] nq[$], mq[$];
   int bad_count = 0, compares = 0;
   frm_fault_response_manager DUT (.clock, .reset, .address, .read, .write, .writedata,
      .readdata(rdata), .waitrequest(wreq), .fault_sources(fs), .vout_sample(vout),
      .iout_sample(iout), .die_temperature(temp), .nvm_request(nvmr), .nvm_is_fault_log(1'b0),
      .nvm_grant(grant), .pwm_top(pt), .pwm_bottom(pb), .top_gate_drive(tg),
      .bottom_gate_drive(bg), .fault_line_in(fw), .fault_line_out(), .fault_line_oe_n(foe),
      .sync_line_in(sw), .sync_line_out(), .sync_line_oe_n(soe), .timebase_line_in(tw),
      .timebase_line_out(), .timebase_line_oe_n(toe), .channel_run_pin_in(rw),
      .channel_run_pin_out(), .channel_run_pin_oe_n(roe), .power_good_output_out(),
      .power_good_output_oe_n(pgo), .power_good(1'b1), .sync_seen(), .timebase_low_seen());
   frm_peer_model u_peer (.fault_oe_n(foe), .sync_oe_n(soe), .timebase_oe_n(toe),
      .run_oe_n(roe), .pull_fault(pf), .pull_sync(ps), .fault_w(fw), .sync_w(sw),
      .timebase_w(tw), .run_w(rw));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // One Avalon transfer; reads leave their expectation in the queue
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
      input logic [31:0] mk);
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      if (!w)
      begin
         nq.push_back(d);
         mq.push_back(mk);
      end
      // Hold the request until waitrequest is sampled low at a rising edge
      do @(posedge clock); while (wreq !== 1'b0);
      write <= 1'b0;
      read <= 1'b0;
   endtask
   // Clock and watchdog
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial
   begin
      #80000;
      bad_count++;
      end_of_test;
   end
   // Read results compared against the oldest note
   always @(posedge clock)
      if (read === 1'b1 && wreq === 1'b0)
      begin
         e = nq.pop_front();
         m = mq.pop_front();
         chk(rdata & m, e & m);
      end
   // Main sequence
   initial
   begin
      static logic [5:0] ra[6] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h28, 6'h3C};
      static logic [31:0] rv[6] = '{32'h3F, 32'h0AAA, 32'h64, 32'h7, 32'h00820078, 32'h0};
      static logic [11:0] tt[4] = '{12'h083, 12'h07D, 12'h077, 12'h07D};
      logic [15:0] v, mx;
      {reset, pt} = 2'b11;
      {read, write, nvmr, pb, pf, ps} = 6'h00;
      {address, fs, writedata, vout, iout} = '0;
      temp = 12'h019;
      void'($urandom(32'hf25a));
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      foreach (ra[i]) bus(0, ra[i], rv[i], 32'hFFFFFFFF);
      bus(1, frm_pkg::ADDR_RESPONSE, 32'h0AA9, 0);
      @(posedge clock) fs <= 6'h01;
      repeat (2) @(negedge clock);
      chk({30'h0, tg, bg}, 32'h1);
      @(posedge clock) fs <= 6'h00;
      bus(0, frm_pkg::ADDR_STATUS, 32'h200, 32'h200);
      bus(0, frm_pkg::ADDR_LOG_COUNT, 32'h1, 32'hFF);
      bus(1, frm_pkg::ADDR_CONTROL, 32'hF, 0);
      bus(0, frm_pkg::ADDR_STATUS, 32'h800, 32'hA00);
      bus(1, frm_pkg::ADDR_RESPONSE, 32'h0A8A, 0);
      bus(1, frm_pkg::ADDR_RETRY_INTERVAL, 32'h0, 0);
      @(posedge clock) fs <= 6'h02;
      repeat (4) @(posedge clock);
      fs <= 6'h00;
      bus(0, frm_pkg::ADDR_STATUS, 32'h400, 32'hC00);
      repeat (300) @(posedge clock);
      bus(0, frm_pkg::ADDR_STATUS, 32'h800, 32'hC00);
      @(posedge clock) fs <= 6'h04;
      repeat (4) @(posedge clock);
      fs <= 6'h00;
      bus(0, frm_pkg::ADDR_STATUS, 32'h800, 32'hC00);
      // Each of the six source classes drives the line only when enabled
      for (int i = 0; i < 6; i++)
      begin
         bus(1, frm_pkg::ADDR_FAULT_ENABLE, 32'h1 << i, 0);
         for (int j = 0; j < 2; j++)
         begin
            @(posedge clock) fs <= 6'h01 << ((i + 1 - j) % 6);
            repeat (4) @(negedge clock);
            chk({31'h0, foe}, {31'h0, j == 0});
         end
         @(posedge clock) fs <= 6'h00;
      end
      @(posedge clock) pf <= 1'b1;
      repeat (6) @(posedge clock);
      bus(0, frm_pkg::ADDR_STATUS, 32'h1000, 32'h1000);
      @(posedge clock) pf <= 1'b0;
      ps <= 1'b1;
      repeat (6) @(posedge clock);
      ps <= 1'b0;
      bus(1, frm_pkg::ADDR_PEAK_VOUT, 32'h0, 0);
      mx = 16'h0000;
      repeat (8)
      begin
         v = 16'($urandom);
         @(posedge clock) vout <= v;
         iout <= 16'($urandom);
         if (v > mx) mx = v;
      end
      bus(0, frm_pkg::ADDR_PEAK_VOUT, {16'h0, mx}, 32'hFFFF);
      @(posedge clock) nvmr <= 1'b1;
      foreach (tt[i])
      begin
         @(posedge clock) temp <= tt[i];
         repeat (5) @(negedge clock);
         chk({31'h0, grant}, {31'h0, i > 1});
      end
      repeat (3000) @(posedge clock);
      chk({31'h0, pgo}, 32'h1);
      end_of_test;
   end
endmodule // fault_response_manager_tb_top
`default_nettype wire
